// file: verilog/dsab_defines.svh
// Timing counts and framing constants for the debug serial auto-baud front end.
`ifndef DSAB_DEFINES_SVH
`define DSAB_DEFINES_SVH
// Data bits per character.
`define DSAB_DATA_BITS      8
// Low bit times in a calibration character (start plus seven data bits).
`define DSAB_CAL_LOW_BITS   8
// Slowest bit rate is the clock divided by this.
`define DSAB_MIN_DIV        512
// Fastest workable bit rate is the clock divided by this.
`define DSAB_MAX_DIV        4
// Low bit times that make a break.
`define DSAB_BREAK_BITS     9
// Idle line level.
`define DSAB_IDLE_LEVEL     1'b1
`endif

// file: verilog/dsab_pkg.sv
// Types shared by the debug serial auto-baud front end.
package dsab_pkg;
  // Top-level link state, one-hot.
  typedef enum logic [4:0] {
    DSAB_ST_WAIT_CAL = 5'b00001,
    DSAB_ST_MEASURE  = 5'b00010,
    DSAB_ST_SETTLE   = 5'b00100,
    DSAB_ST_READY    = 5'b01000,
    DSAB_ST_BREAK    = 5'b10000
  } dsab_state_e;
endpackage

// file: verilog/dsab_bit_if.sv
// Interface carrying the bit period and character strobes to the transmitter.
`timescale 1ns/1ps
interface dsab_bit_if #(parameter int CW = 13);
  logic          calibrated; // Bit period is valid.
  logic [CW-1:0] bit_period; // Clocks per bit.
  logic          tx_valid;   // Character offered.
  logic [7:0]    tx_data;    // Character to send.
  logic          tx_ready;   // Transmitter can take it.
  logic          tx_busy;    // Frame in flight.
  modport ctrl (output calibrated, output bit_period, output tx_valid, output tx_data,
                input tx_ready, input tx_busy);
  modport tx   (input calibrated, input bit_period, input tx_valid, input tx_data,
                output tx_ready, output tx_busy);
endinterface

// file: verilog/dsab_tx.sv
// Transmitter that frames one character at the calibrated bit period.
`timescale 1ns/1ps
`include "dsab_defines.svh"
module dsab_tx
  import dsab_pkg::*;
#(
  parameter int CW = 13
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clear,
  dsab_bit_if.tx    bus,
  output logic      line_out
);
  // ------------------------------------------------------------
  // Frame shifter
  // ------------------------------------------------------------
  logic [9:0]    shift_reg, shift_next;   // Start, data, stop, LSB first.
  logic [3:0]    left_reg, left_next;     // Bits still to send.
  logic [CW-1:0] cnt_reg, cnt_next;       // Clocks into the bit.
  logic          out_reg, out_next;       // Registered line level.

  assign bus.tx_ready = bus.calibrated && (left_reg == 4'h0);
  assign bus.tx_busy  = (left_reg != 4'h0);
  assign line_out     = out_reg;

  // Next state of the shifter; a break clear drops any frame at once.
  always_comb begin
    shift_next = shift_reg;
    left_next  = left_reg;
    cnt_next   = cnt_reg;
    out_next   = out_reg;
    if (clear) begin
      left_next = 4'h0;
      out_next  = `DSAB_IDLE_LEVEL;
    end else if (left_reg == 4'h0) begin
      out_next = `DSAB_IDLE_LEVEL;
      if (bus.tx_valid && bus.calibrated) begin
        shift_next = {1'b1, bus.tx_data, 1'b0};
        left_next  = 4'ha;
        cnt_next   = '0;
        out_next   = 1'b0;
      end
    end else if (cnt_reg == bus.bit_period - CW'(1)) begin
      cnt_next   = '0;
      left_next  = left_reg - 4'h1;
      shift_next = {1'b1, shift_reg[9:1]};
      out_next   = (left_reg == 4'h1) ? `DSAB_IDLE_LEVEL : shift_reg[1];
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  // Registers of the shifter.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 10'h3ff;
      left_reg  <= 4'h0;
      cnt_reg   <= '0;
      out_reg   <= 1'b1;
    end else begin
      shift_reg <= shift_next;
      left_reg  <= left_next;
      cnt_reg   <= cnt_next;
      out_reg   <= out_next;
    end
  end
endmodule

// file: verilog/dsab_top.sv
// Debugger port serial front end with auto-baud detection and break handling.
`timescale 1ns/1ps
`include "dsab_defines.svh"
module dsab_top
  import dsab_pkg::*;
#(
  parameter int CW = 13  // Width of the low-run counter; must hold 8*512.
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       debug_line_in,
  output logic            debug_line_out,
  output logic            debug_line_oe,
  input  wire logic       stop_mode,
  output logic            sys_reset_req,
  output logic            calibrated,
  output logic [CW-4:0]   bit_period,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_frame_err,
  output logic            break_seen,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // counter width check
  if ((1 << CW) <= `DSAB_CAL_LOW_BITS * `DSAB_MIN_DIV)
    $error("dsab_top: CW too small for slowest bit rate");

  localparam int PW = CW - 3;  // Width of one bit period.

  // ------------------------------------------------------------
  // Calibration and break state machine
  // ------------------------------------------------------------
  dsab_state_e   st_reg, st_next;
  logic [CW-1:0] low_reg, low_next;       // Length of the current low run.
  logic [PW-1:0] per_reg, per_next;       // Calibrated clocks per bit.
  logic          prev_reg, prev_next;     // Line level one clock ago.
  logic          heard_reg, heard_next;   // Host has sent data since reset.
  logic          brk_reg, brk_next;       // One-cycle break pulse.
  logic          srst_reg, srst_next;     // System reset request.
  logic          clear;                   // Drops link activity on break.

  // Receiver state.
  logic [3:0]    rbit_reg, rbit_next;     // 0 idle, 1..10 bit positions.
  logic [PW-1:0] rcnt_reg, rcnt_next;     // Clocks toward the next sample.
  logic [7:0]    rsh_reg, rsh_next;       // Data shifter.
  logic [7:0]    rdat_reg, rdat_next;     // Last good character.
  logic          rval_reg, rval_next;     // Character strobe.
  logic          rerr_reg, rerr_next;     // Missing stop bit strobe.

  // Low run has passed nine bit times; only meaningful once calibrated.
  function automatic logic is_break(input logic [CW-1:0] run, input logic [PW-1:0] per);
    is_break = ({3'h0, run} >= (CW + 3)'(`DSAB_BREAK_BITS) * {6'h0, per});
  endfunction

  assign clear = brk_reg;

  // Next state of calibration, break detection and stop-mode reset.
  always_comb begin
    st_next    = st_reg;
    low_next   = low_reg;
    per_next   = per_reg;
    prev_next  = debug_line_in;
    heard_next = heard_reg;
    brk_next   = 1'b0;
    srst_next  = stop_mode && !debug_line_in;
    // run length counted on core clock
    if (!debug_line_in && low_reg != {CW{1'b1}})
      low_next = low_reg + CW'(1);
    else if (debug_line_in)
      low_next = '0;
    case (st_reg)
      DSAB_ST_WAIT_CAL: begin
        if (prev_reg && !debug_line_in) begin
          st_next    = DSAB_ST_MEASURE;
          heard_next = 1'b1;
          low_next   = CW'(1);
        end
      end
      DSAB_ST_MEASURE: begin
        if (debug_line_in) begin
          per_next = low_reg[CW-1:3];
          // refuse runs shorter than clock/4 rate
          if (low_reg < CW'(`DSAB_CAL_LOW_BITS * `DSAB_MAX_DIV))
            st_next = DSAB_ST_WAIT_CAL;
          else
            st_next = DSAB_ST_SETTLE;
        end else if (low_reg == {CW{1'b1}}) begin
          st_next = DSAB_ST_BREAK;
        end
      end
      DSAB_ST_SETTLE: begin
        // Wait one bit time, through the high D7 bit, before listening for frames.
        if (!debug_line_in)
          st_next = DSAB_ST_WAIT_CAL;
        else if (rcnt_reg == per_reg)
          st_next = DSAB_ST_READY;
      end
      DSAB_ST_READY: begin
        if (!debug_line_in && is_break(low_reg, per_reg)) begin
          st_next  = DSAB_ST_BREAK;
          brk_next = 1'b1;
        end
      end
      DSAB_ST_BREAK: begin
        // wait for line high, then recalibrate
        per_next = '0;
        if (debug_line_in)
          st_next = DSAB_ST_WAIT_CAL;
      end
      default: st_next = DSAB_ST_WAIT_CAL;
    endcase
  end

  // Next state of the receiver; it runs only while calibrated.
  always_comb begin
    rbit_next = rbit_reg;
    rcnt_next = rcnt_reg;
    rsh_next  = rsh_reg;
    rdat_next = rdat_reg;
    rval_next = 1'b0;
    rerr_next = 1'b0;
    if (st_reg == DSAB_ST_SETTLE) begin
      // Counts out the high D7 bit of the calibration character.
      rcnt_next = rcnt_reg + PW'(1);
    end else if (st_reg != DSAB_ST_READY || clear) begin
      rbit_next = 4'h0;
      rcnt_next = '0;
    end else if (rbit_reg == 4'h0) begin
      if (!debug_line_in) begin
        // Aim the first sample at the middle of the start bit.
        rbit_next = 4'h1;
        rcnt_next = per_reg >> 1;
      end
    end else if (rcnt_reg == per_reg - PW'(1)) begin
      rcnt_next = '0;
      rbit_next = rbit_reg + 4'h1;
      if (rbit_reg == 4'h1 && debug_line_in) begin
        rbit_next = 4'h0; // False start, a glitch.
      end else if (rbit_reg >= 4'h2 && rbit_reg <= 4'h9) begin
        rsh_next = {debug_line_in, rsh_reg[7:1]};
      end else if (rbit_reg == 4'ha) begin
        rbit_next = 4'h0;
        if (debug_line_in) begin
          rdat_next = rsh_reg;
          rval_next = 1'b1;
        end else begin
          rerr_next = 1'b1;
        end
      end
    end else begin
      rcnt_next = rcnt_reg + PW'(1);
    end
  end

  // Registers of both groups.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= DSAB_ST_WAIT_CAL;
      low_reg   <= '0;
      per_reg   <= '0;
      prev_reg  <= 1'b1;
      heard_reg <= 1'b0;
      brk_reg   <= 1'b0;
      srst_reg  <= 1'b0;
      rbit_reg  <= 4'h0;
      rcnt_reg  <= '0;
      rsh_reg   <= 8'h00;
      rdat_reg  <= 8'h00;
      rval_reg  <= 1'b0;
      rerr_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      low_reg   <= low_next;
      per_reg   <= per_next;
      prev_reg  <= prev_next;
      heard_reg <= heard_next;
      brk_reg   <= brk_next;
      srst_reg  <= srst_next;
      rbit_reg  <= rbit_next;
      rcnt_reg  <= rcnt_next;
      rsh_reg   <= rsh_next;
      rdat_reg  <= rdat_next;
      rval_reg  <= rval_next;
      rerr_reg  <= rerr_next;
    end
  end

  // ------------------------------------------------------------
  // Transmitter and outputs
  // ------------------------------------------------------------
  dsab_bit_if #(.CW(PW)) link ();
  logic line_q;  // Registered transmit level.

  assign link.calibrated = (st_reg == DSAB_ST_READY) && heard_reg;
  assign link.bit_period = per_reg;
  assign link.tx_valid   = tx_valid;
  assign link.tx_data    = tx_data;

  dsab_tx #(.CW(PW)) u_tx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (clear),
    .bus      (link),
    .line_out (line_q)
  );

  // Open-drain style: drive only while sending a low bit.
  assign debug_line_out = 1'b0;
  assign debug_line_oe  = link.tx_busy && !line_q;
  assign tx_ready       = link.tx_ready;
  assign calibrated     = link.calibrated;
  assign bit_period     = per_reg;
  assign rx_data        = rdat_reg;
  assign rx_valid       = rval_reg;
  assign rx_frame_err   = rerr_reg;
  assign break_seen     = brk_reg;
  assign sys_reset_req  = srst_reg;
endmodule

// file: bench/dsab_chk.sv
// Concurrent checks on the ports of the debug serial front end.
`timescale 1ns/1ps
module dsab_chk #(
  parameter int CW = 13
) (
  input wire logic          core_clk,
  input wire logic          rst_n,
  input wire logic          debug_line_in,
  input wire logic          debug_line_out,
  input wire logic          debug_line_oe,
  input wire logic          stop_mode,
  input wire logic          sys_reset_req,
  input wire logic          calibrated,
  input wire logic [CW-4:0] bit_period,
  input wire logic          rx_valid,
  input wire logic          rx_frame_err,
  input wire logic          break_seen,
  input wire logic          tx_valid,
  input wire logic          tx_ready
);
  // One clock domain, so one default clock and reset serve every property.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A request is taken, then the start bit must follow at once.
  sequence s_take; tx_valid && tx_ready; endsequence
  sequence s_start; debug_line_oe && !tx_ready; endsequence
  property p_idle; !calibrated [*2] |-> !debug_line_oe; endproperty
  property p_od; !debug_line_out; endproperty
  property p_start; s_take |=> s_start; endproperty
  property p_busy; debug_line_oe |-> !tx_ready; endproperty
  property p_rdy; tx_ready |-> calibrated; endproperty
  property p_stop; stop_mode && !debug_line_in |=> sys_reset_req; endproperty
  property p_nostop; !stop_mode |=> !sys_reset_req; endproperty
  property p_range; calibrated |-> bit_period >= 4 && bit_period <= 512; endproperty
  property p_hold; $past(calibrated) && calibrated |-> $stable(bit_period); endproperty
  property p_brk; break_seen |=> !calibrated && !break_seen; endproperty
  property p_rx; rx_valid |=> !rx_valid && !rx_frame_err; endproperty
  a_idle : assert property (p_idle) else $error("line driven while not calibrated");
  a_od : assert property (p_od) else $error("drive value not low");
  a_start : assert property (p_start) else $error("start bit missing after take");
  a_busy : assert property (p_busy) else $error("ready while sending");
  a_rdy : assert property (p_rdy) else $error("ready without calibration");
  a_stop : assert property (p_stop) else $error("no reset request in stop");
  a_nostop : assert property (p_nostop) else $error("reset request outside stop");
  a_range : assert property (p_range) else $error("bit period out of range");
  a_hold : assert property (p_hold) else $error("bit period moved");
  a_brk : assert property (p_brk) else $error("break kept calibration");
  a_rx : assert property (p_rx) else $error("receive pulse too long");
endmodule

bind dsab_top dsab_chk #(.CW(CW)) i_dsab_chk (
  .core_clk(core_clk), .rst_n(rst_n), .debug_line_in(debug_line_in),
  .debug_line_out(debug_line_out), .debug_line_oe(debug_line_oe), .stop_mode(stop_mode),
  .sys_reset_req(sys_reset_req), .calibrated(calibrated), .bit_period(bit_period),
  .rx_valid(rx_valid), .rx_frame_err(rx_frame_err), .break_seen(break_seen),
  .tx_valid(tx_valid), .tx_ready(tx_ready));

// file: bench/dsab_host.sv
// Behavioural debug host on the far side of the single-wire line.
`timescale 1ns/1ps
module dsab_host (
  input  wire logic core_clk,
  input  wire logic line,
  output logic      low_drv
);
  // Released line floats to the pull-up level.
  initial low_drv = 1'b0;
  // framed send
  // Start low, data LSB first, then stop; the caller sends 80h first.
  task automatic send(input logic [7:0] b, input int per, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      low_drv = ~f[i];
      repeat (per) @(negedge core_clk);
    end
    low_drv = 1'b0;
  endtask
  task automatic hold_low(input int n);
    low_drv = 1'b1;
    repeat (n) @(negedge core_clk);
    low_drv = 1'b0;
  endtask
  // mid-bit receive
  // Waits for a start bit under a bound, then samples each bit centre.
  task automatic recv(input int per, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (line !== 1'b0 && n < 8 * per + 64) begin
      @(negedge core_clk);
      n++;
    end
    repeat (per / 2) @(negedge core_clk);
    ok = (line === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (per) @(negedge core_clk);
      b[i] = line;
    end
    repeat (per) @(negedge core_clk);
    ok = ok & (line === 1'b1);
  endtask
endmodule

// file: bench/dsab_top_tb_top.sv
// Self-checking bench for the debug serial auto-baud front end.
`timescale 1ns/1ps
module dsab_top_tb_top;
  import dsab_pkg::*;
  localparam int CW = 13;
  logic          core_clk, rst_n, stop_mode, tx_valid, host_low, mon_en, ok;
  logic [7:0]    tx_data, rx_data, b, got;
  logic [CW-4:0] bit_period;
  logic          debug_line_out, debug_line_oe, sys_reset_req, calibrated;
  logic          rx_valid, rx_frame_err, break_seen, tx_ready;
  logic [8:0]    e;
  wire logic     line;
  int            err_count, check_count, brk_count, n;
  logic [8:0]    exp_q[$];
  int            pers[4] = '{4, 8, 37, 512};
  // Open-drain line with a pull-up: low if either side pulls.
  assign line = ~(host_low | debug_line_oe);
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  dsab_top #(.CW(CW)) i_dsab_top (
    .core_clk(core_clk), .rst_n(rst_n), .debug_line_in(line), .debug_line_out(debug_line_out),
    .debug_line_oe(debug_line_oe), .stop_mode(stop_mode), .sys_reset_req(sys_reset_req),
    .calibrated(calibrated), .bit_period(bit_period), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_frame_err(rx_frame_err), .break_seen(break_seen), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  dsab_host i_dsab_host (.core_clk(core_clk), .line(line), .low_drv(host_low));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Calibrate with 80h and wait a bounded time for the high D7 bit to settle it.
  task automatic cal(input int per);
    int k;
    k = 0;
    i_dsab_host.send(8'h80, per, 1'b1);
    while (calibrated !== 1'b1 && k < 2 * per + 40) begin
      @(negedge core_clk);
      k++;
    end
    chk(calibrated, 1);
    chk(bit_period, per);
    repeat (per) @(negedge core_clk);
  endtask
  // Offer a byte once ready shows, waiting at most 100 cycles, so it is taken at the next edge.
  task automatic put(input logic [7:0] d);
    int k;
    k = 0;
    while (tx_ready !== 1'b1 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
    tx_valid = 1'b1;
    tx_data = d;
    @(negedge core_clk);
    tx_valid = 1'b0;
  endtask
  // Receive results are matched against the queue; echo and breaks are masked.
  // Sampled on the falling edge, where the registered strobes have settled.
  always @(negedge core_clk) begin
    if (mon_en && (rx_valid === 1'b1 || rx_frame_err === 1'b1)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      chk(rx_frame_err, e[8]);
      if (!e[8]) chk(rx_data, e[7:0]);
    end
    if (break_seen === 1'b1) brk_count++;
  end
  initial begin
    // The tests need about 40,000 cycles; the limit leaves half as much again.
    #(4 * 60000);
    err_count++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    stop_mode = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    mon_en = 1'b0;
    void'($urandom(32'hfd7f9828));
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    // A transmit request before calibration must be refused silently.
    tx_valid = 1'b1;
    repeat (64) @(negedge core_clk);
    chk(debug_line_oe, 0);
    chk(tx_ready, 0);
    tx_valid = 1'b0;
    stop_mode = 1'b1;
    fork
      i_dsab_host.hold_low(6);
      begin
        repeat (4) @(negedge core_clk);
        chk(sys_reset_req, 1);
      end
    join
    stop_mode = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(sys_reset_req, 0);
    foreach (pers[k]) begin
      cal(pers[k]);
      mon_en = 1'b1;
      for (int j = 0; j < 3; j++) begin
        // A bad-stop frame keeps D7 high so its low run stays short of a break.
        b = 8'($urandom) | ((j == 1) ? 8'h80 : 8'h00);
        exp_q.push_back({j == 1, b});
        i_dsab_host.send(b, pers[k], j != 1);
        repeat (2 * pers[k]) @(negedge core_clk);
      end
      mon_en = 1'b0;
      b = $urandom;
      fork
        put(b);
        i_dsab_host.recv(pers[k], got, ok);
      join
      chk({ok, got}, {1'b1, b});
      n = brk_count;
      i_dsab_host.hold_low(10 * pers[k] + 8);
      repeat (2 * pers[k] + 8) @(negedge core_clk);
      chk(brk_count, n + 1);
      chk(calibrated, 0);
    end
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule
